// >>> shared/tpc_map.svh
// command codes, status codes and field positions of the tape controller host port
// assumes one 125 MHz system clock; included by bare name
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
// ----------------------------------------
// command word, low byte
// ----------------------------------------
`define TPC_CMD_READ 8'h01
`define TPC_CMD_STOP 8'h02
`define TPC_CMD_INH 8'h04
`define TPC_CMD_READ_INH 8'h05
`define TPC_CMD_STOP_INH 8'h06
`define TPC_CMD_ALLOW 8'h08
`define TPC_CMD_READ_ALLOW 8'h09
`define TPC_CMD_STOP_ALLOW 8'h0a
`define TPC_CMD_BIT_READ 0
`define TPC_CMD_BIT_STOP 1
`define TPC_CMD_BIT_INH 2
`define TPC_CMD_BIT_ALLOW 3
// ----------------------------------------
// status bytes and bus lanes
// ----------------------------------------
`define TPC_STAT_OK 8'h00
`define TPC_STAT_TERR 8'h04
`define TPC_STAT_NRDY 8'h40
`define TPC_BUS_MSB_LINE 8
`define TPC_BUS_LSB_LINE 15
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define TPC_MIN_CHARS 2'd2
`define TPC_EOT_EXTRA 2'd2
`define TPC_RST_BYTE 8'h00
`endif

// >>> shared/tpc_pkg.sv
// types shared by the tape controller host port
// assumes tpc_map.svh holds the numeric constants
package tpc_pkg;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef enum logic {TPC_SECT_RX, TPC_SECT_TX} tpc_sect_t;
   typedef struct packed {
      logic cmd;
      logic din;
      logic dout;
      logic ain;
      logic sin;
      tpc_sect_t sect;
      logic [7:0] data;
   } tpc_cpu_req_t;
   typedef struct packed {
      logic run_sw;
      logic spool_pwr;
      logic rewind_off;
      logic char_stb;
      logic [7:0] char_data;
      logic punch_ready;
      logic near_eot;
      logic punch_done;
   } tpc_dev_in_t;
endpackage : tpc_pkg

// >>> logic/tpc_host_port.sv
// host port of the perforated tape controller: command, data, address and status strobes
// assumes the cpu presents level strobes with data stable while high; reader/punch give pulses
`timescale 1ns/1ns
`include "tpc_map.svh"
module tpc_host_port #(
   parameter logic [7:0] RX_ADDR = 8'h11, // arbitrary section address
   parameter logic [7:0] TX_ADDR = 8'h13  // arbitrary section address
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire tpc_pkg::tpc_cpu_req_t I_CPU_REQ,
   input wire logic I_HIGHER_LEVEL,
   input wire tpc_pkg::tpc_dev_in_t I_DEV,
   output logic O_ACK,
   output logic O_BUS_OE,
   output logic [0:15] O_BUS_DATA,
   output logic O_RX_IRQ,
   output logic O_TX_IRQ,
   output logic O_READER_RUN,
   output logic O_PUNCH_STB,
   output logic [7:0] O_PUNCH_DATA
);
   import tpc_pkg::*;
   // ----------------------------------------
   // input synchronisers and edge detect
   // ----------------------------------------
   tpc_cpu_req_t req_m, req_s, req_d;
   tpc_dev_in_t dev_m, dev_s, dev_d;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         req_m <= '0;
         req_s <= '0;
         req_d <= '0;
         dev_m <= '0;
         dev_s <= '0;
         dev_d <= '0;
      end else begin
         req_m <= I_CPU_REQ;
         req_s <= req_m;
         req_d <= req_s;
         dev_m <= I_DEV;
         dev_s <= dev_m;
         dev_d <= dev_s;
      end
   end
   logic cmd_ev, din_ev, dout_ev, ain_ev, sin_ev, char_ev, done_ev, to_rx;
   assign cmd_ev = req_s.cmd & ~req_d.cmd;
   assign din_ev = req_s.din & ~req_d.din;
   assign dout_ev = req_s.dout & ~req_d.dout;
   assign ain_ev = req_s.ain & ~req_d.ain;
   assign sin_ev = req_s.sin & ~req_d.sin;
   assign char_ev = dev_s.char_stb & ~dev_d.char_stb;
   assign done_ev = dev_s.punch_done & ~dev_d.punch_done;
   assign to_rx = (req_s.sect == TPC_SECT_RX);
   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic rx_cmd_ok, tx_cmd_ok, rx_not_ready, tx_punch_ok;
   always_comb begin
      unique case (req_s.data)
         `TPC_CMD_READ, `TPC_CMD_STOP, `TPC_CMD_INH, `TPC_CMD_READ_INH,
         `TPC_CMD_STOP_INH, `TPC_CMD_ALLOW, `TPC_CMD_READ_ALLOW, `TPC_CMD_STOP_ALLOW: rx_cmd_ok = to_rx;
         default: rx_cmd_ok = 1'b0;
      endcase
      tx_cmd_ok = !to_rx && (req_s.data == `TPC_CMD_INH || req_s.data == `TPC_CMD_ALLOW);
   end
   assign rx_not_ready = !(dev_s.run_sw && dev_s.spool_pwr && dev_s.rewind_off);
   assign tx_punch_ok = dev_s.punch_ready && !dev_s.near_eot;
   // ----------------------------------------
   // controller state
   // ----------------------------------------
   logic reading_r, reading_nxt, stop_pend_r, stop_pend_nxt;
   logic [1:0] char_cnt_r, char_cnt_nxt, eot_cnt_r, eot_cnt_nxt;
   logic rx_full_r, rx_full_nxt, rx_terr_r, rx_terr_nxt, rx_nrdy_r, rx_nrdy_nxt;
   logic rx_inh_r, rx_inh_nxt, rx_irq_r, rx_irq_nxt;
   logic [7:0] rx_buf_r, rx_buf_nxt, punch_data_r, punch_data_nxt;
   logic tx_busy_r, tx_busy_nxt, tx_svc_r, tx_svc_nxt, tx_nrdy_r, tx_nrdy_nxt;
   logic tx_inh_r, tx_inh_nxt, tx_irq_r, tx_irq_nxt;
   logic ack_r, ack_nxt, oe_r, oe_nxt, pstb_r, pstb_nxt;
   logic [0:15] bus_r, bus_nxt;
   always_comb begin
      reading_nxt = reading_r;
      stop_pend_nxt = stop_pend_r;
      char_cnt_nxt = char_cnt_r;
      eot_cnt_nxt = dev_s.near_eot ? eot_cnt_r : 2'd0;
      rx_full_nxt = rx_full_r;
      rx_terr_nxt = rx_terr_r;
      rx_nrdy_nxt = rx_nrdy_r;
      rx_inh_nxt = rx_inh_r;
      rx_irq_nxt = rx_irq_r;
      rx_buf_nxt = rx_buf_r;
      punch_data_nxt = punch_data_r;
      tx_busy_nxt = tx_busy_r;
      tx_svc_nxt = tx_svc_r;
      tx_nrdy_nxt = tx_nrdy_r;
      tx_inh_nxt = tx_inh_r;
      tx_irq_nxt = tx_irq_r;
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
      pstb_nxt = 1'b0;
      bus_nxt = bus_r;
      // cpu strobes act first so that a device event in the same cycle wins
      if (cmd_ev && rx_cmd_ok) begin
         ack_nxt = 1'b1;
         rx_terr_nxt = 1'b0;
         if (req_s.data[`TPC_CMD_BIT_INH]) begin
            rx_inh_nxt = 1'b1;
            rx_irq_nxt = 1'b0;
         end
         if (req_s.data[`TPC_CMD_BIT_ALLOW]) begin
            rx_inh_nxt = 1'b0;
            rx_irq_nxt = rx_full_r | rx_nrdy_r;
         end
         if (req_s.data[`TPC_CMD_BIT_READ]) begin
            if (!rx_not_ready) begin
               reading_nxt = 1'b1;
               stop_pend_nxt = 1'b0;
               char_cnt_nxt = 2'd0;
            end else begin
               rx_nrdy_nxt = 1'b1;
               rx_irq_nxt = !rx_inh_nxt;
            end
         end
         if (req_s.data[`TPC_CMD_BIT_STOP] && reading_r) begin
            stop_pend_nxt = 1'b1;
         end
      end
      if (cmd_ev && tx_cmd_ok) begin
         ack_nxt = 1'b1;
         if (req_s.data[`TPC_CMD_BIT_INH]) begin
            tx_inh_nxt = 1'b1;
            tx_irq_nxt = 1'b0;
         end else begin
            tx_inh_nxt = 1'b0;
            tx_irq_nxt = tx_svc_r | tx_nrdy_r;
         end
      end
      if (din_ev && to_rx) begin
         oe_nxt = 1'b1;
         bus_nxt = '0;
         bus_nxt[`TPC_BUS_MSB_LINE:`TPC_BUS_LSB_LINE] = rx_buf_r;
         // a timing error or not-ready flag withholds the ack until status in (or, for the error, a command) clears it; a dead reader withholds it while dead
         ack_nxt = rx_full_r && !rx_terr_r && !rx_nrdy_r && !rx_not_ready;
         rx_full_nxt = 1'b0;
         rx_irq_nxt = 1'b0;
      end
      if (dout_ev && !to_rx) begin
         if (!tx_busy_r && tx_punch_ok) begin
            ack_nxt = 1'b1;
            tx_svc_nxt = 1'b0;
            tx_irq_nxt = 1'b0;
         end
         if (!tx_busy_r && dev_s.punch_ready && dev_s.near_eot && eot_cnt_r != `TPC_EOT_EXTRA) begin
            eot_cnt_nxt = eot_cnt_r + 2'd1;
            tx_svc_nxt = 1'b0;
            if (eot_cnt_r == 2'd0) begin
               tx_nrdy_nxt = 1'b1;
               tx_irq_nxt = !tx_inh_r;
            end else begin
               ack_nxt = 1'b1;
               tx_irq_nxt = 1'b0;
            end
         end
         if (!tx_busy_r && (tx_punch_ok || (dev_s.punch_ready && eot_cnt_r != `TPC_EOT_EXTRA))) begin
            tx_busy_nxt = 1'b1;
            pstb_nxt = 1'b1;
            punch_data_nxt = req_s.data;
         end
         if (!tx_busy_r && !dev_s.punch_ready) begin
            tx_nrdy_nxt = 1'b1;
         end
      end
      if (ain_ev) begin
         // receiver outranks transmitter; an outside higher level silences both
         if (!I_HIGHER_LEVEL && rx_irq_r && !rx_inh_r) begin
            oe_nxt = 1'b1;
            bus_nxt = '0;
            bus_nxt[`TPC_BUS_MSB_LINE:`TPC_BUS_LSB_LINE] = RX_ADDR;
            rx_irq_nxt = 1'b0;
         end else if (!I_HIGHER_LEVEL && tx_irq_r && !tx_inh_r) begin
            oe_nxt = 1'b1;
            bus_nxt = '0;
            bus_nxt[`TPC_BUS_MSB_LINE:`TPC_BUS_LSB_LINE] = TX_ADDR;
            tx_irq_nxt = 1'b0;
         end
      end
      if (sin_ev) begin
         oe_nxt = 1'b1;
         bus_nxt = '0;
         if (to_rx) begin
            bus_nxt[`TPC_BUS_MSB_LINE:`TPC_BUS_LSB_LINE] = (rx_nrdy_r || rx_not_ready) ? `TPC_STAT_NRDY :
               (rx_terr_r ? `TPC_STAT_TERR : `TPC_STAT_OK);
            rx_irq_nxt = 1'b0;
            rx_terr_nxt = 1'b0;
            rx_nrdy_nxt = 1'b0;
         end else begin
            bus_nxt[`TPC_BUS_MSB_LINE:`TPC_BUS_LSB_LINE] = (tx_nrdy_r || !tx_punch_ok) ? `TPC_STAT_NRDY :
               `TPC_STAT_OK;
            tx_irq_nxt = 1'b0;
            tx_nrdy_nxt = 1'b0;
         end
      end
      // device events: sets win over same-cycle clears
      if (char_ev && reading_r) begin
         if (rx_full_r) begin
            rx_terr_nxt = 1'b1;
         end
         rx_buf_nxt = dev_s.char_data;
         rx_full_nxt = 1'b1;
         rx_irq_nxt = rx_irq_nxt | !rx_inh_nxt;
         if (char_cnt_r != `TPC_MIN_CHARS) begin
            char_cnt_nxt = char_cnt_r + 2'd1;
         end
         if (stop_pend_nxt && char_cnt_r != 2'd0) begin
            reading_nxt = 1'b0;
            stop_pend_nxt = 1'b0;
         end
      end
      if (done_ev && tx_busy_r) begin
         tx_busy_nxt = 1'b0;
         tx_svc_nxt = 1'b1;
         tx_irq_nxt = tx_irq_nxt | !tx_inh_nxt;
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         reading_r <= 1'b0;
         stop_pend_r <= 1'b0;
         char_cnt_r <= 2'd0;
         eot_cnt_r <= 2'd0;
         rx_full_r <= 1'b0;
         rx_terr_r <= 1'b0;
         rx_nrdy_r <= 1'b0;
         rx_inh_r <= 1'b0;
         rx_irq_r <= 1'b0;
         rx_buf_r <= `TPC_RST_BYTE;
         punch_data_r <= `TPC_RST_BYTE;
         tx_busy_r <= 1'b0;
         tx_svc_r <= 1'b0;
         tx_nrdy_r <= 1'b0;
         tx_inh_r <= 1'b0;
         tx_irq_r <= 1'b0;
         ack_r <= 1'b0;
         oe_r <= 1'b0;
         pstb_r <= 1'b0;
         bus_r <= '0;
      end else begin
         reading_r <= reading_nxt;
         stop_pend_r <= stop_pend_nxt;
         char_cnt_r <= char_cnt_nxt;
         eot_cnt_r <= eot_cnt_nxt;
         rx_full_r <= rx_full_nxt;
         rx_terr_r <= rx_terr_nxt;
         rx_nrdy_r <= rx_nrdy_nxt;
         rx_inh_r <= rx_inh_nxt;
         rx_irq_r <= rx_irq_nxt;
         rx_buf_r <= rx_buf_nxt;
         punch_data_r <= punch_data_nxt;
         tx_busy_r <= tx_busy_nxt;
         tx_svc_r <= tx_svc_nxt;
         tx_nrdy_r <= tx_nrdy_nxt;
         tx_inh_r <= tx_inh_nxt;
         tx_irq_r <= tx_irq_nxt;
         ack_r <= ack_nxt;
         oe_r <= oe_nxt;
         pstb_r <= pstb_nxt;
         bus_r <= bus_nxt;
      end
   end
   assign O_ACK = ack_r;
   assign O_BUS_OE = oe_r;
   assign O_BUS_DATA = bus_r;
   assign O_RX_IRQ = rx_irq_r;
   assign O_TX_IRQ = tx_irq_r;
   assign O_READER_RUN = reading_r;
   assign O_PUNCH_STB = pstb_r;
   assign O_PUNCH_DATA = punch_data_r;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_READ_READY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      $rose(reading_r) |-> !$past(rx_not_ready)) else $error("reader started while not ready");
   AST_READ_CLR_TERR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (cmd_ev && rx_cmd_ok && !char_ev) |=> !rx_terr_r && O_ACK) else $error("command left timing error");
   AST_MIN_TWO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      $fell(reading_r) |-> char_cnt_r == `TPC_MIN_CHARS) else $error("reader stopped before two chars");
   AST_RX_INHIBIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (cmd_ev && rx_cmd_ok && req_s.data[`TPC_CMD_BIT_INH]) |=> !O_RX_IRQ[*2]) else $error("rx request not dropped");
   AST_TX_INHIBIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (cmd_ev && tx_cmd_ok && req_s.data[`TPC_CMD_BIT_INH]) |=> !O_TX_IRQ && tx_inh_r) else $error("tx request kept");
   AST_ALLOW_REISSUE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (cmd_ev && rx_cmd_ok && req_s.data[`TPC_CMD_BIT_ALLOW] && rx_full_r && !din_ev) |=> O_RX_IRQ)
      else $error("allow did not reissue request");
   AST_DIN_CLEARS: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (din_ev && to_rx && !char_ev) |=> !rx_full_r ##1 !O_ACK) else $error("data in left service set");
   AST_OVERRUN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (char_ev && reading_r && rx_full_r) |=> rx_terr_r) else $error("overrun not flagged");
   AST_BUSY_NOACK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (dout_ev && !to_rx && tx_busy_r) |=> !O_ACK && !O_PUNCH_STB) else $error("busy punch acknowledged");
   AST_AIN_INHIBITED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (ain_ev && rx_inh_r) |=> !O_ACK && !(O_BUS_OE && O_BUS_DATA[`TPC_BUS_MSB_LINE:`TPC_BUS_LSB_LINE] == RX_ADDR))
      else $error("address in answered while inhibited");
   AST_SIN_ANSWER: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      sin_ev |=> O_BUS_OE && !O_ACK && ($past(to_rx) ? (!O_RX_IRQ || $past(char_ev)) : (!O_TX_IRQ || $past(done_ev))))
      else $error("status in not answered");
endmodule : tpc_host_port

// >>> verification/tpc_dev_model.sv
// reader and punch model standing behind the tape controller host port
// assumes the bench requests each character; punch cycle length is a parameter
`timescale 1ns/1ns
module tpc_dev_model #(
   parameter int PUNCH_CYC = 20
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_char_req,
   input wire logic i_reader_run,
   input wire logic i_punch_stb,
   output logic o_char_stb,
   output logic [7:0] o_char_data,
   output logic o_punch_done
);
   // ----------------------------------------
   // reader and punch timing
   // ----------------------------------------
   logic [7:0] ch_r;
   logic [3:0] ccnt_r;
   logic [5:0] pcnt_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ch_r <= 8'hc0;
         ccnt_r <= 4'h0;
         pcnt_r <= 6'h00;
      end else begin
         // a stopped reader moves no tape, so requests are dropped
         if (i_char_req && i_reader_run && ccnt_r == 4'h0) begin
            ccnt_r <= 4'h9;
         end else if (ccnt_r != 4'h0) begin
            ccnt_r <= ccnt_r - 4'h1;
         end
         if (ccnt_r == 4'h1) begin
            ch_r <= ch_r + 8'h01;
         end
         if (i_punch_stb) begin
            pcnt_r <= PUNCH_CYC[5:0];
         end else if (pcnt_r != 6'h00) begin
            pcnt_r <= pcnt_r - 6'h01;
         end
      end
   end
   // data lines show the inverse outside a character so a stale byte never passes
   assign o_char_stb = ccnt_r > 4'h3;
   assign o_char_data = (ccnt_r != 4'h0) ? ch_r : ~ch_r;
   assign o_punch_done = pcnt_r != 6'h00 && pcnt_r < 6'h05;
endmodule : tpc_dev_model

// >>> verification/testbench.sv
// self-checking bench for the tape controller host port
// assumes tpc_dev_model plays reader and punch; the bench plays the cpu
`timescale 1ns/1ns
`include "tpc_map.svh"
module testbench;
   import tpc_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam logic [7:0] RX_A = 8'h11;
   localparam logic [7:0] TX_A = 8'h13;
   localparam logic [2:0] R_ACK = 3'b100;
   localparam logic [2:0] R_OE = 3'b010;
   localparam logic [2:0] R_PUN = 3'b001;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic higher = 1'b0;
   logic run_sw = 1'b1;
   logic spool_pwr = 1'b1;
   logic rewind_off = 1'b1;
   logic punch_ready = 1'b1;
   logic near_eot = 1'b0;
   logic char_req = 1'b0;
   tpc_cpu_req_t req = '0;
   tpc_dev_in_t dev;
   logic cstb, pdone, ack, oe, rx_irq, tx_irq, run, pstb, a, o, p;
   logic [7:0] cdata, pdata, b, last;
   logic [7:0] ch = 8'hc0;
   logic [0:15] bus;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   assign dev = {run_sw, spool_pwr, rewind_off, cstb, cdata, punch_ready, near_eot, pdone};
   always #4 clk = ~clk;
   tpc_host_port #(.RX_ADDR(RX_A), .TX_ADDR(TX_A)) dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_CPU_REQ(req),
      .I_HIGHER_LEVEL(higher), .I_DEV(dev), .O_ACK(ack), .O_BUS_OE(oe), .O_BUS_DATA(bus), .O_RX_IRQ(rx_irq),
      .O_TX_IRQ(tx_irq), .O_READER_RUN(run), .O_PUNCH_STB(pstb), .O_PUNCH_DATA(pdata));
   tpc_dev_model #(.PUNCH_CYC(20)) model_u (.i_clk(clk), .i_rst_n(rst_n), .i_char_req(char_req),
      .i_reader_run(run), .i_punch_stb(pstb), .o_char_stb(cstb), .o_char_data(cdata), .o_punch_done(pdone));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   // k: 0 command, 1 data in, 2 data out, 3 address in, 4 status in; strobe held two cycles
   task automatic cpu_op(input int k, input logic s, input logic [7:0] d);
      @(negedge clk);
      req.sect = tpc_sect_t'(s);
      req.data = d;
      {req.cmd, req.din, req.dout, req.ain, req.sin} = 5'h10 >> k;
      {a, o, p, b} = 11'h000;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         if (i == 1) begin
            {req.cmd, req.din, req.dout, req.ain, req.sin} = 5'h00;
         end
         a |= ack;
         p |= pstb;
         if (oe) begin
            o = 1'b1;
            b = bus[8:15];
         end
      end
   endtask : cpu_op
   task automatic resp(input logic [2:0] e);
      check({5'h00, a, o, p}, {5'h00, e});
   endtask : resp
   task automatic send_char;
      @(negedge clk);
      char_req = 1'b1;
      @(negedge clk);
      char_req = 1'b0;
      repeat (14) @(negedge clk);
      last = ch;
      ch = ch + 8'h01;
   endtask : send_char
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_not_ready;
      logic [7:0] codes [3] = '{`TPC_CMD_READ_ALLOW, `TPC_CMD_READ, `TPC_CMD_READ_INH};
      logic [7:0] bad [4] = '{8'h03, 8'h0c, 8'h11, `TPC_CMD_READ};
      @(negedge clk);
      check({ack, oe, rx_irq, tx_irq, run, pstb, 2'b00}, 8'h00);
      check(bus[8:15], 8'h00);
      for (int i = 0; i < 3; i++) begin
         {run_sw, spool_pwr, rewind_off} = ~(3'b001 << i);
         cpu_op(0, 1'b0, codes[i]);
         resp(R_ACK);
         check({7'h00, run}, 8'h00);
         cpu_op(4, 1'b0, 8'h00);
         resp(R_OE);
         check(b, `TPC_STAT_NRDY);
      end
      {run_sw, spool_pwr, rewind_off} = 3'b111;
      for (int i = 0; i < 4; i++) begin
         cpu_op(0, i == 3, bad[i]);
         resp(3'b000);
      end
   endtask : t_not_ready
   task automatic t_rx_data;
      logic [7:0] codes [3] = '{`TPC_CMD_READ_INH, `TPC_CMD_ALLOW, `TPC_CMD_INH};
      cpu_op(0, 1'b0, `TPC_CMD_READ_INH);
      resp(R_ACK);
      check({7'h00, run}, 8'h01);
      cpu_op(1, 1'b0, 8'h00);
      resp(R_OE);
      cpu_op(4, 1'b0, 8'h00);
      check(b, `TPC_STAT_OK);
      send_char();
      cpu_op(1, 1'b0, 8'h00); // polled well inside the character spacing
      resp(R_ACK | R_OE);
      check(b, last);
      for (int i = 0; i < 3; i++) begin
         send_char();
         send_char();
         if (i == 0) begin
            cpu_op(1, 1'b0, 8'h00);
            resp(R_OE);
            cpu_op(4, 1'b0, 8'h00);
            check(b, `TPC_STAT_TERR);
            send_char();
            send_char();
         end
         cpu_op(0, 1'b0, codes[i]);
         check({7'h00, rx_irq}, {7'h00, i == 1});
         cpu_op(4, 1'b0, 8'h00);
         check(b, `TPC_STAT_OK);
      end
      cpu_op(1, 1'b0, 8'h00);
      resp(R_ACK | R_OE);
      check(b, last);
   endtask : t_rx_data
   task automatic t_rx_irq;
      cpu_op(0, 1'b0, `TPC_CMD_ALLOW);
      send_char();
      cpu_op(0, 1'b0, `TPC_CMD_INH);
      check({7'h00, rx_irq}, 8'h00);
      cpu_op(3, 1'b0, 8'h00);
      resp(3'b000);
      cpu_op(0, 1'b0, `TPC_CMD_ALLOW);
      check({7'h00, rx_irq}, 8'h01);
      higher = 1'b1;
      cpu_op(3, 1'b0, 8'h00);
      resp(3'b000);
      higher = 1'b0;
      cpu_op(3, 1'b0, 8'h00);
      resp(R_OE);
      check(b, RX_A);
      check({7'h00, rx_irq}, 8'h00);
      cpu_op(1, 1'b0, 8'h00);
      resp(R_ACK | R_OE);
      check(b, last);
   endtask : t_rx_irq
   task automatic t_stop;
      logic [7:0] codes [3] = '{`TPC_CMD_STOP, `TPC_CMD_STOP_ALLOW, `TPC_CMD_STOP_INH};
      for (int i = 0; i < 3; i++) begin
         cpu_op(0, 1'b0, `TPC_CMD_READ);
         cpu_op(0, 1'b0, codes[i]); // stop issued right after the read command, before any character
         resp(R_ACK);
         for (int n = 0; n < 2; n++) begin
            check({7'h00, run}, 8'h01);
            send_char();
            cpu_op(1, 1'b0, 8'h00);
            resp(R_ACK | R_OE);
            check(b, last);
         end
         check({7'h00, run}, 8'h00);
      end
   endtask : t_stop
   task automatic t_punch;
      cpu_op(0, 1'b1, `TPC_CMD_ALLOW);
      resp(R_ACK);
      cpu_op(2, 1'b1, 8'h5a);
      resp(R_ACK | R_PUN);
      check(pdata, 8'h5a);
      cpu_op(2, 1'b1, 8'h33);
      resp(3'b000);
      cpu_op(4, 1'b1, 8'h00);
      check(b, `TPC_STAT_OK);
      repeat (40) @(negedge clk);
      cpu_op(0, 1'b1, `TPC_CMD_INH);
      check({7'h00, tx_irq}, 8'h00);
      cpu_op(3, 1'b0, 8'h00);
      resp(3'b000);
      cpu_op(0, 1'b1, `TPC_CMD_ALLOW);
      check({7'h00, tx_irq}, 8'h01);
      cpu_op(3, 1'b0, 8'h00);
      check(b, TX_A);
      check({7'h00, tx_irq}, 8'h00);
      cpu_op(2, 1'b1, 8'h66);
      repeat (40) @(negedge clk);
      cpu_op(2, 1'b1, 8'h77);
      resp(R_ACK | R_PUN);
      check({7'h00, tx_irq}, 8'h00);
      repeat (40) @(negedge clk);
      punch_ready = 1'b0;
      cpu_op(2, 1'b1, 8'h01);
      resp(3'b000);
      cpu_op(4, 1'b1, 8'h00);
      check(b, `TPC_STAT_NRDY);
      punch_ready = 1'b1;
      near_eot = 1'b1;
      cpu_op(2, 1'b1, 8'hc3);
      resp(R_PUN);
      repeat (40) @(negedge clk);
      cpu_op(2, 1'b1, 8'h3c);
      resp(R_ACK | R_PUN);
      check(pdata, 8'h3c);
      repeat (40) @(negedge clk);
      cpu_op(2, 1'b1, 8'h99);
      resp(3'b000);
      cpu_op(4, 1'b1, 8'h00);
      check({7'h00, tx_irq}, 8'h00);
      near_eot = 1'b0;
   endtask : t_punch
   // reset in mid-run with the reader running and a request up; the model restarts too, so this runs last
   task automatic t_reset;
      cpu_op(0, 1'b0, `TPC_CMD_READ_ALLOW);
      resp(R_ACK);
      send_char();
      check({6'h00, rx_irq, run}, 8'h03);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      check({ack, oe, rx_irq, tx_irq, run, pstb, 2'b00}, 8'h00);
      check(bus[8:15], 8'h00);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      check({ack, oe, rx_irq, tx_irq, run, pstb, 2'b00}, 8'h00);
      check(pdata, `TPC_RST_BYTE);
      cpu_op(1, 1'b0, 8'h00);
      resp(R_OE);
      check(b, `TPC_RST_BYTE);
   endtask : t_reset
   // ----------------------------------------
   // run and watchdog
   // ----------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_not_ready();
      t_rx_data();
      t_rx_irq();
      t_stop();
      t_punch();
      t_reset();
      complete_run();
   end
endmodule : testbench
